/* rtl/cri_comparator_ctrl.sv */
// Notes on behaviour
// - output change versus latched value sets flag
// - flag at bit 3; only software clears
// - writing 1 sets flag, simulated interrupt
// - live comparator output readable at bit 6
// - request needs comparator, peripheral, global enables
// - flag still sets while request disabled
// - control access re-latches output as reference
// - persisting mismatch keeps setting the flag
// - change during control read may be missed
// - reference control: power, range, level fields
// - low range: level times supply over 24
// - high range: quarter plus level over 32
// - invert bit flips reported comparator polarity
// - reset clears controls but sets pin directions to 3F, mode 000, reference off
// - comparator interrupt wakes device; registers kept
//
// Our own choice: the strobed register port.
module cri_comparator_ctrl #(
    parameter int SYNC_STAGES = cri_pkg::SYNC_STAGES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [cri_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cri_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cri_pkg::DATA_W-1:0] reg_rdata,
    // analog comparator side
    input wire logic cmp_raw,
    output logic [cri_pkg::MODE_W-1:0] cmp_mode_select,
    output logic cmp_input_switch,
    output logic [5:0] pin_direction,
    // reference ladder side
    output logic ref_power_on,
    output logic ref_range_select,
    output logic [cri_pkg::LEVEL_W-1:0] ref_level,
    output logic [cri_pkg::TAP_W-1:0] ref_tap,
    // core side
    input wire logic sleep_active,
    output logic cmp_irq_req,
    output logic wake_req,
    output logic irq
);

    // refuse depths that cannot resynchronise
    // a single flop would let a metastable level reach the compare
    // and the flag logic at the same time, so two is the floor
    if (SYNC_STAGES < 2) begin : g_bad_depth
        $error("SYNC_STAGES must be at least 2");
    end

    // true when the port address selects the given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // synchroniser chain for the raw comparator output
    logic [SYNC_STAGES-1:0] sync_q;
    logic [SYNC_STAGES-1:0] sync_d;

    // register state
    // every software visible register keeps a _q flop and a _d next
    // value; unimplemented bits are masked on the write path so that
    // reads never have to mask again
    logic [7:0] int_ctrl_q, int_ctrl_d; // global and peripheral enables
    logic [7:0] flags_q, flags_d; // peripheral flags
    logic [7:0] enables_q, enables_d; // peripheral enables
    logic [4:0] cmp_ctrl_q, cmp_ctrl_d; // invert, switch, mode
    logic [5:0] pin_dir_q, pin_dir_d; // pin directions
    logic [7:0] ref_ctrl_q, ref_ctrl_d; // reference control
    logic latched_q, latched_d; // reference for mismatch
    logic prev_q, prev_d; // previous result, for change events
    logic [7:0] evt_stat_q, evt_stat_d; // sticky event status
    logic [7:0] evt_en_q, evt_en_d; // event enables
    logic [7:0] rdata_q, rdata_d; // read data
    logic [6:0] tap_q, tap_d; // ladder tap in 96ths
    logic req_q, req_d; // core interrupt request
    logic wake_q, wake_d; // wake from sleep
    logic irq_q, irq_d; // event interrupt line

    // decoded helpers
    logic cmp_result; // polarity-corrected result
    logic cmp_access; // any access to comparator control
    logic mismatch; // result differs from latched value
    logic change; // one-cycle change of the result

    // synchroniser: stage 0 feeds only stage 1
    // the raw comparator level is free running with respect to mclk;
    // only the last stage is read by the rest of the block
    always_comb begin
        sync_d = {sync_q[SYNC_STAGES-2:0], cmp_raw};
    end

    // synchroniser flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_q <= '0;
        end else begin
            sync_d_reg: sync_q <= sync_d;
        end
    end

    // result, mismatch and access decode
    // the latched value is the reference that software last saw;
    // mismatch stays true until the result falls back to it or an access of the control register
    // copies the present result into it
    always_comb begin
        // invert applied after the synchroniser
        cmp_result = sync_q[SYNC_STAGES-1]
            ^ cmp_ctrl_q[cri_pkg::BIT_CMP_INVERT];
        cmp_access = (reg_rd | reg_wr)
            & hit(reg_addr, cri_pkg::OFF_CMP_CTRL);
        mismatch = cmp_result != latched_q;
        change = cmp_result != prev_q;
    end

    // next state of the register file and flags
    // defaults hold every register but prev_q, which takes the result; the write decode below then
    // overrides, and the hardware set paths come last so that they
    // win over a software clear in the same cycle
    always_comb begin
        int_ctrl_d = int_ctrl_q;
        flags_d = flags_q;
        enables_d = enables_q;
        cmp_ctrl_d = cmp_ctrl_q;
        pin_dir_d = pin_dir_q;
        ref_ctrl_d = ref_ctrl_q;
        evt_en_d = evt_en_q;
        evt_stat_d = evt_stat_q;
        prev_d = cmp_result;
        latched_d = latched_q;

        // writes store only implemented bits
        if (reg_wr) begin
            if (hit(reg_addr, cri_pkg::OFF_INT_CTRL)
                || hit(reg_addr, cri_pkg::OFF_INT_CTRL_ALT)) begin
                int_ctrl_d = reg_wdata;
            end
            if (hit(reg_addr, cri_pkg::OFF_PERIPH_FLAGS)) begin
                // writing 1 or 0 to the flag bit
                flags_d = reg_wdata & cri_pkg::MASK_PERIPH;
            end
            if (hit(reg_addr, cri_pkg::OFF_PERIPH_EN)) begin
                enables_d = reg_wdata & cri_pkg::MASK_PERIPH;
            end
            if (hit(reg_addr, cri_pkg::OFF_CMP_CTRL)) begin
                // result bit position is dropped
                cmp_ctrl_d = reg_wdata[4:0];
            end
            if (hit(reg_addr, cri_pkg::OFF_PIN_DIR)) begin
                pin_dir_d = reg_wdata[5:0];
            end
            if (hit(reg_addr, cri_pkg::OFF_REF_CTRL)) begin
                // unimplemented bits 6 and 4 stay zero
                ref_ctrl_d = reg_wdata & cri_pkg::MASK_REF_CTRL;
            end
            if (hit(reg_addr, cri_pkg::OFF_EVT_ENABLE)) begin
                evt_en_d = reg_wdata & cri_pkg::MASK_EVT;
            end
            if (hit(reg_addr, cri_pkg::OFF_EVT_CLEAR)) begin
                // write one to clear
                evt_stat_d = evt_stat_q & ~reg_wdata;
            end
        end

        // access ends the mismatch by re-latching
        // reads and writes both count, so a service routine may use
        // either to acknowledge the change it has seen
        if (cmp_access) begin
            latched_d = cmp_result;
        end

        // mismatch keeps setting the flag, winning over a clear;
        // a coincident control access masks it for that cycle
        if (mismatch && !cmp_access) begin
            flags_d[cri_pkg::BIT_CMP_FLAG] = 1'b1;
        end

        // sticky event, set wins over clear
        if (change) begin
            evt_stat_d[cri_pkg::BIT_EVT_CHANGE] = 1'b1;
        end
    end

    // register file flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            // reset values: mode 000, reference off
            int_ctrl_q <= cri_pkg::RST_INT_CTRL;
            flags_q <= cri_pkg::RST_PERIPH_FLAGS;
            enables_q <= cri_pkg::RST_PERIPH_EN;
            cmp_ctrl_q <= cri_pkg::RST_CMP_CTRL[4:0];
            pin_dir_q <= cri_pkg::RST_PIN_DIR[5:0];
            ref_ctrl_q <= cri_pkg::RST_REF_CTRL;
            evt_en_q <= cri_pkg::RST_EVT;
            evt_stat_q <= cri_pkg::RST_EVT;
            prev_q <= 1'b0;
            latched_q <= 1'b0;
        end else begin
            // sleep does not touch these registers
            int_ctrl_q <= int_ctrl_d;
            flags_q <= flags_d;
            enables_q <= enables_d;
            cmp_ctrl_q <= cmp_ctrl_d;
            pin_dir_q <= pin_dir_d;
            ref_ctrl_q <= ref_ctrl_d;
            evt_en_q <= evt_en_d;
            evt_stat_q <= evt_stat_d;
            prev_q <= prev_d;
            latched_q <= latched_d;
        end
    end

    // read mux, answer in the next cycle
    // data stand for exactly one cycle and fall back to zero, so a
    // bus that ors several slaves together sees nothing stale
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (hit(reg_addr, cri_pkg::OFF_INT_CTRL)
                || hit(reg_addr, cri_pkg::OFF_INT_CTRL_ALT)) begin
                rdata_d = int_ctrl_q;
            end else if (hit(reg_addr, cri_pkg::OFF_PERIPH_FLAGS)) begin
                rdata_d = flags_q;
            end else if (hit(reg_addr, cri_pkg::OFF_PERIPH_EN)) begin
                rdata_d = enables_q;
            end else if (hit(reg_addr, cri_pkg::OFF_CMP_CTRL)) begin
                // live result at bit 6, bits 7 and 5 read zero
                rdata_d = {1'b0, cmp_result, 1'b0, cmp_ctrl_q};
            end else if (hit(reg_addr, cri_pkg::OFF_PIN_DIR)) begin
                rdata_d = {2'h0, pin_dir_q};
            end else if (hit(reg_addr, cri_pkg::OFF_REF_CTRL)) begin
                rdata_d = ref_ctrl_q;
            end else if (hit(reg_addr, cri_pkg::OFF_EVT_STATUS)) begin
                rdata_d = evt_stat_q;
            end else if (hit(reg_addr, cri_pkg::OFF_EVT_ENABLE)) begin
                rdata_d = evt_en_q;
            end else begin
                // unmapped and write-only offsets read zero
                rdata_d = 8'h00;
            end
        end
    end

    // ladder tap and interrupt outputs
    // the tap is counted in 96ths of supply, the smallest unit that
    // both ranges hit exactly, so the ladder needs no rounding
    // the request paths use the next flag value so that the core
    // sees a request in the same cycle as the flag itself
    always_comb begin
        logic [3:0] lvl;
        lvl = ref_ctrl_q[3:0];
        if (!ref_ctrl_q[cri_pkg::BIT_REF_POWER]) begin
            // powered down ladder has no tap
            tap_d = 7'h00;
        end else if (ref_ctrl_q[cri_pkg::BIT_REF_RANGE]) begin
            // low range: 4 ninety-sixths per level
            tap_d = 7'({3'h0, lvl} * cri_pkg::TAP_LOW_STEP);
        end else begin
            // high range: quarter plus 3 ninety-sixths per level
            tap_d = 7'(cri_pkg::TAP_HIGH_BASE
                + {3'h0, lvl} * cri_pkg::TAP_HIGH_STEP);
        end
        // request only when all three enables are set
        req_d = flags_d[cri_pkg::BIT_CMP_FLAG]
            & enables_q[cri_pkg::BIT_CMP_EN]
            & int_ctrl_q[cri_pkg::BIT_PERIPH_EN]
            & int_ctrl_q[cri_pkg::BIT_GLOBAL_EN];
        // wake needs only the comparator enable while asleep
        wake_d = sleep_active & flags_d[cri_pkg::BIT_CMP_FLAG]
            & enables_q[cri_pkg::BIT_CMP_EN];
        irq_d = |(evt_stat_d & evt_en_d);
    end

    // output flops
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            tap_q <= 7'h00;
            req_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            tap_q <= tap_d;
            req_q <= req_d;
            wake_q <= wake_d;
            irq_q <= irq_d;
        end
    end

    // port drive, all from flops
    // nothing below adds logic: each port is a wire onto a register
    // so the far side never sees a glitch from the decode
    assign reg_rdata = rdata_q;
    assign cmp_mode_select = cmp_ctrl_q[2:0];
    assign cmp_input_switch = cmp_ctrl_q[cri_pkg::BIT_CMP_SWITCH];
    assign pin_direction = pin_dir_q;
    assign ref_power_on = ref_ctrl_q[cri_pkg::BIT_REF_POWER];
    assign ref_range_select = ref_ctrl_q[cri_pkg::BIT_REF_RANGE];
    assign ref_level = ref_ctrl_q[3:0];
    assign ref_tap = tap_q;
    assign cmp_irq_req = req_q;
    assign wake_req = wake_q;
    assign irq = irq_q;

endmodule : cri_comparator_ctrl

/* rtl/cri_pkg.sv */
package cri_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets on the register port
    localparam logic [7:0] OFF_INT_CTRL = 8'h0B;
    localparam logic [7:0] OFF_INT_CTRL_ALT = 8'h8B;
    localparam logic [7:0] OFF_PERIPH_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_CMP_CTRL = 8'h19;
    localparam logic [7:0] OFF_PIN_DIR = 8'h85;
    localparam logic [7:0] OFF_PERIPH_EN = 8'h8C;
    localparam logic [7:0] OFF_REF_CTRL = 8'h99;
    localparam logic [7:0] OFF_EVT_STATUS = 8'hA0;
    localparam logic [7:0] OFF_EVT_CLEAR = 8'hA1;
    localparam logic [7:0] OFF_EVT_ENABLE = 8'hA2;

    // values after reset
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
    localparam logic [7:0] RST_CMP_CTRL = 8'h00;
    localparam logic [7:0] RST_PIN_DIR = 8'h3F;
    localparam logic [7:0] RST_PERIPH_EN = 8'h00;
    localparam logic [7:0] RST_REF_CTRL = 8'h00;
    localparam logic [7:0] RST_EVT = 8'h00;

    // implemented bits of each register
    localparam logic [7:0] MASK_PERIPH = 8'hC9;
    localparam logic [7:0] MASK_PIN_DIR = 8'h3F;
    localparam logic [7:0] MASK_REF_CTRL = 8'hAF;
    localparam logic [7:0] MASK_CMP_WR = 8'h1F;
    localparam logic [7:0] MASK_EVT = 8'h01;

    // field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_EN = 6;
    localparam int BIT_CMP_FLAG = 3;
    localparam int BIT_CMP_EN = 3;
    localparam int BIT_CMP_RESULT = 6;
    localparam int BIT_CMP_INVERT = 4;
    localparam int BIT_CMP_SWITCH = 3;
    localparam int BIT_REF_POWER = 7;
    localparam int BIT_REF_RANGE = 5;
    localparam int BIT_EVT_CHANGE = 0;
    localparam int MODE_W = 3;
    localparam int LEVEL_W = 4;

    // ladder tap in 96ths of supply: 96 is common to 24 and 32
    localparam int TAP_W = 7;
    localparam logic [6:0] TAP_HIGH_BASE = 7'h18;
    localparam logic [6:0] TAP_LOW_STEP = 7'h04;
    localparam logic [6:0] TAP_HIGH_STEP = 7'h03;

    // synchroniser depth
    localparam int SYNC_STAGES = 2;

endpackage : cri_pkg

/* sim/cri_cmp_model.sv */
module cri_cmp_model (
    // ladder tap from the block
    input wire logic [6:0] ref_tap,
    input wire logic ref_power_on,
    // analog input level in 96ths of supply
    input wire logic [6:0] vin_level,
    // raw comparator output
    output logic cmp_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    // unpowered ladder leaves the output low
    always_comb begin
        cmp_raw = ref_power_on && (vin_level > ref_tap);
    end
endmodule : cri_cmp_model

/* sim/cri_comparator_ctrl_props.sv */
module cri_comparator_ctrl_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // comparator, ladder and core side
    input wire logic [2:0] cmp_mode_select,
    input wire logic [5:0] pin_direction,
    input wire logic ref_power_on,
    input wire logic ref_range_select,
    input wire logic [3:0] ref_level,
    input wire logic [6:0] ref_tap,
    input wire logic sleep_active,
    input wire logic cmp_irq_req,
    input wire logic wake_req
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // write strobe aimed at the reference control
    sequence s_ref_wr;
        reg_wr && reg_addr == 8'h99;
    endsequence
    // write strobe aimed at the comparator control
    sequence s_mode_wr;
        reg_wr && reg_addr == 8'h19;
    endsequence
    a_reset_vals: assert property ($fell(rst) |-> cmp_mode_select == 3'h0
        && !ref_power_on && pin_direction == 6'h3F && !cmp_irq_req)
        else $error("outputs not at reset values");
    a_ref_write: assert property (s_ref_wr |=>
        ref_power_on == $past(reg_wdata[7]) && ref_level == $past(reg_wdata[3:0])
        && ref_range_select == $past(reg_wdata[5]))
        else $error("reference fields not taken");
    a_ref_hold: assert property (!(reg_wr && reg_addr == 8'h99) |=>
        $stable({ref_power_on, ref_range_select, ref_level}))
        else $error("reference fields moved");
    a_mode_write: assert property (s_mode_wr |=>
        cmp_mode_select == $past(reg_wdata[2:0]))
        else $error("mode field not taken");
    a_tap_off: assert property (!$past(ref_power_on) |-> ref_tap == 7'h00)
        else $error("tap active while ladder off");
    a_tap_low: assert property ($past(ref_power_on && ref_range_select) |->
        ref_tap == {1'b0, $past(ref_level), 2'b00})
        else $error("low range tap wrong");
    a_tap_high: assert property ($past(ref_power_on && !ref_range_select) |->
        ref_tap == 7'h18 + 7'($past(ref_level)) * 7'h03)
        else $error("high range tap wrong");
    a_wake_gate: assert property (wake_req |-> $past(sleep_active))
        else $error("wake request while awake");
endmodule : cri_comparator_ctrl_props

bind cri_comparator_ctrl cri_comparator_ctrl_props u_props (.mclk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .cmp_mode_select, .pin_direction,
    .ref_power_on, .ref_range_select, .ref_level, .ref_tap, .sleep_active,
    .cmp_irq_req, .wake_req);

/* sim/cri_comparator_ctrl_tb.sv */
module cri_comparator_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // stimulus
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_active = 1'b0;
    logic [6:0] vin_level = 7'h00;
    // observed
    logic [7:0] reg_rdata;
    logic [2:0] cmp_mode_select;
    logic [5:0] pin_direction;
    logic [3:0] ref_level;
    logic [6:0] ref_tap;
    logic cmp_raw, cmp_input_switch, ref_power_on, ref_range_select;
    logic cmp_irq_req, wake_req, irq;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    cri_comparator_ctrl uut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cmp_raw, .cmp_mode_select, .cmp_input_switch,
        .pin_direction, .ref_power_on, .ref_range_select, .ref_level,
        .ref_tap, .sleep_active, .cmp_irq_req, .wake_req, .irq);
    cri_cmp_model far (.ref_tap, .ref_power_on, .vin_level, .cmp_raw);

    // free running clock
    initial begin
        forever #20 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_n
    // one cycle write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // one cycle read, data judged in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    // move the analog input and let the synchroniser settle
    task automatic set_vin(input logic [6:0] v);
        @(posedge mclk);
        vin_level <= v;
        wait_n(6);
    endtask : set_vin

    task automatic t_reset();
        logic [7:0] offs [8] = '{8'h0B, 8'h0C, 8'h19, 8'h85, 8'h8C, 8'h99,
            8'h55, 8'hA1};
        for (int i = 0; i < 8; i++) begin
            rd(offs[i], (i == 3) ? 8'h3F : 8'h00);
        end
    endtask : t_reset
    task automatic t_ref();
        logic [3:0] lv;
        logic [7:0] e;
        wr(8'h99, 8'hFF);
        rd(8'h99, 8'hAF);
        for (int r = 0; r < 2; r++) begin
            for (int l = 0; l < 2; l++) begin
                lv = l ? 4'hF : 4'h0;
                e = r ? 8'(lv) * 8'h04 : 8'h18 + 8'(lv) * 8'h03;
                wr(8'h99, {2'b10, r[0], 1'b0, lv});
                wait_n(2);
                chk({1'b0, ref_tap}, e);
            end
        end
        wr(8'h99, 8'h88);
    endtask : t_ref
    task automatic t_flag();
        wr(8'h8C, 8'h08);
        wr(8'h0B, 8'hC0);
        set_vin(7'h3C);
        chk({7'h00, cmp_irq_req}, 8'h01);
        rd(8'h0C, 8'h08);
        wr(8'h0C, 8'h00);
        rd(8'h0C, 8'h08);
        rd(8'h19, 8'h40);
        wr(8'h0C, 8'h00);
        rd(8'h0C, 8'h00);
        wr(8'h0C, 8'h08);
        rd(8'h0C, 8'h08);
        wr(8'h0C, 8'h00);
    endtask : t_flag
    task automatic t_quiet();
        wr(8'h0B, 8'h40);
        set_vin(7'h14);
        rd(8'h0C, 8'h08);
        chk({7'h00, cmp_irq_req}, 8'h00);
        @(posedge mclk);
        sleep_active <= 1'b1;
        wait_n(2);
        chk({7'h00, wake_req}, 8'h01);
        @(posedge mclk);
        sleep_active <= 1'b0;
        rd(8'h19, 8'h00);
        wr(8'h0C, 8'h00);
    endtask : t_quiet
    task automatic t_invert();
        wr(8'h19, 8'hFF);
        wait_n(4);
        chk({7'h00, cmp_input_switch}, 8'h01);
        chk({5'h00, cmp_mode_select}, 8'h07);
        rd(8'h19, 8'h5F);
        wr(8'h19, 8'h00);
        wait_n(4);
        rd(8'h19, 8'h00);
    endtask : t_invert
    task automatic t_event();
        wr(8'hA1, 8'h01);
        rd(8'hA0, 8'h00);
        wr(8'hA2, 8'h01);
        wait_n(2);
        chk({7'h00, irq}, 8'h00);
        set_vin(7'h3C);
        chk({7'h00, irq}, 8'h01);
        wr(8'hA2, 8'h00);
        wait_n(2);
        chk({7'h00, irq}, 8'h00);
        rd(8'hA0, 8'h01);
        wr(8'hA1, 8'h01);
        rd(8'hA0, 8'h00);
    endtask : t_event

    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_ref();
        t_flag();
        t_quiet();
        t_invert();
        t_event();
        final_report();
    end
endmodule : cri_comparator_ctrl_tb
